/* File: rtl/press_motion_supervisor.sv */
// module: shaft position, motion supervision, stop outputs, programs
`timescale 1ns/1ps
`default_nettype none
module press_motion_supervisor #(
    parameter int TICK_CYCLES = press_motion_pkg::TICK_CYCLES,
    parameter int unsigned MIN_CYCLES = press_motion_pkg::MIN_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // resolver and press inputs
    input wire logic [8:0] i_raw_angle,
    input wire logic i_brake,
    input wire logic i_fault_reset,
    input wire logic i_stop_fault,
    input wire logic i_top_stop_sel,
    // permit inputs, active low
    input wire logic i_program_permit_n,
    input wire logic i_supervisor_permit_n,
    // setup entry
    input wire logic i_set_offset,
    input wire logic i_set_upper,
    input wire logic i_set_lower,
    input wire logic i_set_timer,
    input wire logic i_set_top,
    input wire logic i_set_mute,
    input wire logic i_step_entry,
    input wire logic [9:0] i_set_value,
    // program management
    input wire logic i_prog_req,
    input wire press_motion_pkg::prog_op_e i_prog_op,
    input wire logic i_prog_confirm,
    input wire logic [5:0] i_prog_target,
    input wire logic [47:0] i_prog_name,
    input wire logic [31:0] i_prog_data,
    input wire logic i_select,
    input wire logic [5:0] i_select_slot,
    // position and rate
    output logic [8:0] o_position,
    output logic [8:0] o_offset,
    output logic [9:0] o_stroke_rate,
    output logic o_moving,
    // stop outputs, high is energized
    output logic o_motion,
    output logic o_top_stop,
    output logic o_immediate_stop,
    output logic o_no_motion_fault,
    output logic [9:0] o_fault_rate,
    // setup readback
    output logic [9:0] o_upper_rate_limit,
    output logic [9:0] o_lower_rate_limit,
    output logic [9:0] o_timer_preset,
    output logic [8:0] o_top_angle,
    output logic [8:0] o_mute_angle,
    output logic o_set_refused,
    // program status
    output logic [5:0] o_tool_program_slot,
    output logic [47:0] o_slot_name,
    output logic [31:0] o_slot_data,
    output logic o_prog_busy,
    output logic o_prog_done,
    output logic o_prog_bad_name
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [8:0] offset;
        logic [8:0] pos;
        logic [8:0] last_raw;
        logic [31:0] rev_cnt;
        logic [9:0] rate;
        logic [9:0] upper;
        logic [9:0] lower;
        logic [9:0] preset;
        logic [8:0] top;
        logic [8:0] mute;
        logic refused;
        logic brake_d;
        logic timing;
        logic [31:0] tick_cnt;
        logic [9:0] elapsed;
        logic motion;
        logic low_tripped;
        logic armed;
        logic fault;
        logic [9:0] fault_rate;
        logic top_stop;
        logic istop;
        logic [5:0] slot;
    } st_s;
    st_s s_q, s_d;
    prog_store_if ps ();
    // corrected angle with wrap at 360
    function automatic logic [8:0] add_wrap(input logic [8:0] a,
        input logic [8:0] b);
        logic [9:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        if (sum >= {1'b0, press_motion_pkg::ANGLE_FULL}) begin
            sum = sum - {1'b0, press_motion_pkg::ANGLE_FULL};
        end
        return sum[8:0];
    endfunction
    // shaft moved forward onto or over a mark since the last cycle
    function automatic logic passed(input logic [8:0] prev,
        input logic [8:0] now, input logic [8:0] mark);
        if (now >= prev) begin
            return prev < mark && mark <= now;
        end
        return mark > prev || mark <= now;
    endfunction
    logic permit;
    logic moving;
    logic wrapped;
    logic in_band;
    logic [31:0] rate_full;
    logic [8:0] pos_now;
    // ==========================================================
    // combinational next state
    always_comb begin
        s_d = s_q;
        rate_full = '0;
        permit = !i_program_permit_n && !i_supervisor_permit_n;
        pos_now = add_wrap(i_raw_angle, s_q.offset);
        s_d.pos = pos_now;
        s_d.last_raw = i_raw_angle;
        moving = s_q.rate != '0 || i_raw_angle != s_q.last_raw;
        wrapped = i_raw_angle < s_q.last_raw;
        // revolution period to strokes per minute
        if (wrapped) begin
            if (s_q.rev_cnt != '0) begin
                rate_full = 32'(MIN_CYCLES) / s_q.rev_cnt;
            end
            s_d.rate = (rate_full > 32'h3FF) ? 10'h3FF : rate_full[9:0];
            s_d.rev_cnt = 32'h1;
        end else if (s_q.rev_cnt >= 32'(MIN_CYCLES)) begin
            s_d.rate = '0; // under one stroke per minute
            s_d.rev_cnt = s_q.rev_cnt;
        end else begin
            s_d.rev_cnt = s_q.rev_cnt + 32'h1;
        end
        // setup writes
        s_d.refused = 1'b0;
        if (i_set_offset || i_set_upper || i_set_lower || i_set_timer ||
            i_set_top || i_set_mute) begin
            if (!permit) begin
                s_d.refused = 1'b1;
            end else if (moving && !i_step_entry) begin
                s_d.refused = 1'b1;
            end else if (i_set_offset) begin
                if (moving) begin
                    s_d.refused = 1'b1;
                end else if (i_set_value <= {1'b0,
                    press_motion_pkg::ANGLE_MAX}) begin
                    s_d.offset = i_set_value[8:0];
                end else begin
                    s_d.refused = 1'b1;
                end
            end else if (i_set_upper) begin
                s_d.upper = i_set_value;
            end else if (i_set_lower) begin
                s_d.lower = i_set_value;
            end else if (i_set_timer) begin
                if (i_set_value <= press_motion_pkg::TIMER_MAX) begin
                    s_d.preset = i_set_value;
                end else begin
                    s_d.refused = 1'b1;
                end
            end else if (i_set_top) begin
                if (i_set_value <= {1'b0, press_motion_pkg::ANGLE_MAX}) begin
                    s_d.top = i_set_value[8:0];
                end else begin
                    s_d.refused = 1'b1;
                end
            end else begin
                if (i_set_value >= {1'b0, press_motion_pkg::MUTE_MIN} &&
                    i_set_value <= {1'b0, press_motion_pkg::MUTE_END}) begin
                    s_d.mute = i_set_value[8:0];
                end else begin
                    s_d.refused = 1'b1;
                end
            end
        end
        // low limit drop and zero-rate restart
        in_band = s_q.rate <= s_q.upper && s_q.rate >= s_q.lower;
        if (s_q.rate == '0) begin
            s_d.low_tripped = 1'b0;
            s_d.armed = 1'b0;
        end else if (s_q.rate >= s_q.lower) begin
            s_d.armed = 1'b1; // run-up from rest must not trip
        end else if (s_q.armed) begin
            s_d.low_tripped = 1'b1;
        end
        // no-motion timer from brake falling edge
        s_d.brake_d = i_brake;
        if (s_q.brake_d && !i_brake && !s_q.fault) begin
            s_d.timing = 1'b1;
            s_d.tick_cnt = '0;
            s_d.elapsed = '0;
        end else if (s_q.timing) begin
            if (in_band) begin
                s_d.timing = 1'b0;
            end else if (s_q.elapsed >= s_q.preset) begin
                s_d.timing = 1'b0;
                s_d.fault = 1'b1;
                s_d.fault_rate = s_q.rate;
            end else if (s_q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
                s_d.tick_cnt = '0;
                s_d.elapsed = s_q.elapsed + 10'h001;
            end else begin
                s_d.tick_cnt = s_q.tick_cnt + 32'h1;
            end
        end
        // only the remote reset clears; an expiry this cycle wins
        if (i_fault_reset && !(s_q.timing && s_d.fault)) begin
            s_d.fault = 1'b0;
        end
        s_d.motion = !s_d.low_tripped && !s_d.fault;
        // top stop and immediate stop
        if (i_stop_fault && i_top_stop_sel &&
            passed(s_q.pos, pos_now, s_q.top)) begin
            s_d.top_stop = 1'b0;
        end
        if (i_stop_fault && !i_top_stop_sel) begin
            if (!(pos_now >= s_q.mute && pos_now <= press_motion_pkg::MUTE_END)) begin
                s_d.istop = 1'b0;
            end
        end
        if (i_fault_reset) begin
            s_d.top_stop = 1'b1;
            s_d.istop = 1'b1;
        end
        // selection from explicit choice or search hit
        if (i_select && permit) begin
            s_d.slot = i_select_slot;
        end else if (ps.done && ps.found) begin
            s_d.slot = ps.found_slot;
        end
    end
    // ==========================================================
    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.motion <= 1'b1;
            s_q.top_stop <= 1'b1;
            s_q.istop <= 1'b1;
            s_q.mute <= press_motion_pkg::MUTE_END;
            s_q.preset <= press_motion_pkg::TIMER_MAX;
        end else begin
            s_q <= s_d;
        end
    end
    // ==========================================================
    // program store
    assign ps.req = i_prog_req && permit;
    assign ps.op = i_prog_op;
    assign ps.confirm = i_prog_confirm;
    assign ps.slot = s_q.slot;
    assign ps.target = i_prog_target;
    assign ps.name = i_prog_name;
    assign ps.data = i_prog_data;
    prog_store u_store (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .bus(ps),
        .i_rd_slot(s_q.slot),
        .o_rd_name(o_slot_name),
        .o_rd_data(o_slot_data)
    );
    // outputs
    assign o_position = s_q.pos;
    assign o_offset = s_q.offset;
    assign o_stroke_rate = s_q.rate;
    assign o_moving = s_q.rate != '0;
    assign o_motion = s_q.motion;
    assign o_top_stop = s_q.top_stop;
    assign o_immediate_stop = s_q.istop;
    assign o_no_motion_fault = s_q.fault;
    assign o_fault_rate = s_q.fault_rate;
    assign o_upper_rate_limit = s_q.upper;
    assign o_lower_rate_limit = s_q.lower;
    assign o_timer_preset = s_q.preset;
    assign o_top_angle = s_q.top;
    assign o_mute_angle = s_q.mute;
    assign o_set_refused = s_q.refused;
    assign o_tool_program_slot = s_q.slot;
    assign o_prog_busy = ps.busy;
    assign o_prog_done = ps.done;
    assign o_prog_bad_name = ps.bad_name;
endmodule // press_motion_supervisor
`default_nettype wire

/* File: shared/press_motion_pkg.sv */
// package: constants and types for the press motion supervisor
package press_motion_pkg;
    localparam int ANGLE_W = 9;
    localparam logic [8:0] ANGLE_MAX = 9'h167;     // 359 degrees
    localparam logic [8:0] ANGLE_FULL = 9'h168;    // 360 degrees
    localparam logic [8:0] MUTE_MIN = 9'h05A;      // 90 degrees
    localparam logic [8:0] MUTE_END = 9'h0BE;      // 190 degrees
    localparam int RATE_W = 10;
    localparam int TIMER_W = 10;                   // hundredths of seconds
    localparam logic [9:0] TIMER_MAX = 10'h3E7;    // 9.99 s
    localparam int CLK_HZ = 50000000;
    localparam int TICK_MS = 10;                   // timer resolution
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned MIN_CYCLES = unsigned'(CLK_HZ) * 32'd60; // minute
    localparam int SLOTS = 64;
    localparam int SLOT_W = 6;
    localparam int NAME_LEN = 8;
    localparam int CHAR_W = 6;
    localparam int PROG_W = 32;                    // per-program payload
    localparam logic [5:0] CH_BLANK = 6'h00;
    localparam logic [5:0] CH_DIGIT0 = 6'h01;      // 0..9 -> 01..0A
    localparam logic [5:0] CH_ALPHA_A = 6'h0B;     // A..Z -> 0B..24
    localparam logic [5:0] CH_HYPHEN = 6'h25;
    localparam logic [5:0] CH_QUERY = 6'h26;       // also search wildcard
    localparam logic [5:0] CH_LAST = 6'h26;
    typedef enum logic [2:0] {
        OP_NONE, OP_SEARCH, OP_RENAME, OP_DELETE, OP_COPY
    } prog_op_e;
endpackage

/* File: shared/prog_store_if.sv */
// interface: program store request from supervisor to store
`timescale 1ns/1ps
`default_nettype none
interface prog_store_if;
    logic req;
    press_motion_pkg::prog_op_e op;
    logic confirm;
    logic [5:0] slot;
    logic [5:0] target;
    logic [47:0] name;
    logic [31:0] data;
    logic busy;
    logic done;
    logic found;
    logic [5:0] found_slot;
    logic bad_name;
    modport master (output req, op, confirm, slot, target, name, data,
        input busy, done, found, found_slot, bad_name);
    modport store (input req, op, confirm, slot, target, name, data,
        output busy, done, found, found_slot, bad_name);
endinterface
`default_nettype wire

/* File: rtl/prog_store.sv */
// module: tool program names and data, with search, rename, delete, copy
`timescale 1ns/1ps
`default_nettype none
module prog_store (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // request port
    prog_store_if.store bus,
    // read back of a slot
    input wire logic [5:0] i_rd_slot,
    output logic [47:0] o_rd_name,
    output logic [31:0] o_rd_data
);
    localparam int NW = press_motion_pkg::NAME_LEN * press_motion_pkg::CHAR_W;
    typedef struct packed {
        logic busy;
        logic done;
        logic found;
        logic bad;
        logic [5:0] scan;
        logic [5:0] start;
        logic [5:0] fslot;
        logic [47:0] rd_name;
        logic [31:0] rd_data;
    } st_s;
    st_s s_q, s_d;
    logic [NW-1:0] names [press_motion_pkg::SLOTS];
    logic [31:0] datas [press_motion_pkg::SLOTS];
    // wildcard compare over every character position
    function automatic logic name_match(input logic [47:0] pat,
        input logic [47:0] nm);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < press_motion_pkg::NAME_LEN; i++) begin
            if (pat[i*6 +: 6] != press_motion_pkg::CH_QUERY &&
                pat[i*6 +: 6] != nm[i*6 +: 6]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction
    // character set check: blank, digits, letters, hyphen, query
    function automatic logic name_legal(input logic [47:0] nm);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < press_motion_pkg::NAME_LEN; i++) begin
            if (nm[i*6 +: 6] > press_motion_pkg::CH_LAST) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction
    logic wr_en;
    logic [5:0] wr_slot;
    logic [47:0] wr_name;
    logic [31:0] wr_data;
    // next state and write port
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        wr_en = 1'b0;
        wr_slot = bus.slot;
        wr_name = names[bus.slot];
        wr_data = datas[bus.slot];
        s_d.rd_name = names[i_rd_slot];
        s_d.rd_data = datas[i_rd_slot];
        if (s_q.busy) begin
            // search walks slots after the selected slot and wraps round
            if (name_match(bus.name, names[s_q.scan])) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.found = 1'b1;
                s_d.fslot = s_q.scan;
            end else if (s_q.scan == s_q.start) begin
                s_d.busy = 1'b0; // no hit: selection unchanged
                s_d.done = 1'b1;
                s_d.found = 1'b0;
            end else begin
                s_d.scan = s_q.scan + 6'h01;
            end
        end else if (bus.req) begin
            s_d.done = 1'b1;
            s_d.bad = 1'b0;
            s_d.found = 1'b0;
            case (bus.op)
                press_motion_pkg::OP_SEARCH: begin
                    s_d.done = 1'b0;
                    s_d.busy = 1'b1;
                    s_d.scan = bus.slot + 6'h01;
                    s_d.start = bus.slot;
                end
                press_motion_pkg::OP_RENAME: begin
                    if (name_legal(bus.name)) begin
                        wr_en = 1'b1;
                        wr_name = bus.name;
                    end else begin
                        s_d.bad = 1'b1;
                    end
                end
                press_motion_pkg::OP_DELETE: begin
                    if (bus.confirm) begin
                        wr_en = 1'b1;
                        wr_name = '0;
                        wr_data = '0;
                    end
                end
                press_motion_pkg::OP_COPY: begin
                    if (bus.confirm) begin
                        wr_en = 1'b1;
                        wr_slot = bus.target;
                    end
                end
                default: begin
                    s_d.done = 1'b1;
                end
            endcase
        end
    end
    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // program memory, not reset
    always_ff @(posedge i_clk) begin
        if (wr_en) begin
            names[wr_slot] <= wr_name;
            datas[wr_slot] <= wr_data;
        end
    end
    assign bus.busy = s_q.busy;
    assign bus.done = s_q.done;
    assign bus.found = s_q.found;
    assign bus.found_slot = s_q.fslot;
    assign bus.bad_name = s_q.bad;
    assign o_rd_name = s_q.rd_name;
    assign o_rd_data = s_q.rd_data;
endmodule // prog_store
`default_nettype wire

/* File: tb/press_motion_sva.sv */
// checker: port assertions for the press motion supervisor
`timescale 1ns/1ps
`default_nettype none
module press_motion_sva (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // watched inputs
    input wire logic i_set_offset,
    input wire logic i_program_permit_n,
    input wire logic i_supervisor_permit_n,
    input wire logic i_fault_reset,
    input wire logic i_prog_req,
    input wire press_motion_pkg::prog_op_e i_prog_op,
    // watched outputs
    input wire logic [8:0] o_position,
    input wire logic [8:0] o_offset,
    input wire logic o_moving,
    input wire logic o_motion,
    input wire logic o_no_motion_fault,
    input wire logic [9:0] o_fault_rate,
    input wire logic [9:0] o_timer_preset,
    input wire logic [8:0] o_mute_angle,
    input wire logic o_prog_busy,
    input wire logic o_prog_done
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ==================================================
    // assertions
    a_offset_range: assert property (
        o_offset <= press_motion_pkg::ANGLE_MAX) else $error("offset range");
    a_position_wrap: assert property (
        o_position <= press_motion_pkg::ANGLE_MAX) else $error("position wrap");
    a_offset_frozen: assert property (
        i_set_offset && o_moving |=> $stable(o_offset)) else $error("moving");
    a_permit_gate: assert property (
        i_set_offset && (i_program_permit_n || i_supervisor_permit_n)
        |=> $stable(o_offset)) else $error("permit gate");
    a_fault_latched: assert property (
        o_no_motion_fault && !i_fault_reset |=> o_no_motion_fault)
        else $error("fault dropped");
    a_fault_motion: assert property (
        $rose(o_no_motion_fault) |-> ##[0:2] !o_motion) else $error("motion");
    a_fault_rate: assert property (
        o_no_motion_fault && $past(o_no_motion_fault) |-> $stable(o_fault_rate))
        else $error("fault rate");
    a_timer_ceiling: assert property (
        o_timer_preset <= press_motion_pkg::TIMER_MAX) else $error("preset");
    a_mute_window: assert property (
        $changed(o_mute_angle) |-> o_mute_angle inside
        {[press_motion_pkg::MUTE_MIN:press_motion_pkg::MUTE_END]})
        else $error("mute angle");
    a_prog_answer: assert property (
        i_prog_req && !o_prog_busy && !i_program_permit_n &&
        !i_supervisor_permit_n && i_prog_op inside
        {press_motion_pkg::OP_DELETE, press_motion_pkg::OP_COPY}
        |-> ##[1:3] o_prog_done) else $error("prog answer");
    // main scenarios reached
    c_fault: cover property ($rose(o_no_motion_fault));
    c_done: cover property (o_prog_done);
    c_frozen: cover property (i_set_offset && o_moving);
endmodule // press_motion_sva
bind press_motion_supervisor press_motion_sva u_sva (
    .i_clk(i_clk), .i_rst(i_rst), .i_set_offset(i_set_offset),
    .i_program_permit_n(i_program_permit_n), .i_prog_req(i_prog_req),
    .i_supervisor_permit_n(i_supervisor_permit_n), .i_prog_op(i_prog_op),
    .i_fault_reset(i_fault_reset), .o_position(o_position),
    .o_offset(o_offset), .o_moving(o_moving), .o_motion(o_motion),
    .o_no_motion_fault(o_no_motion_fault), .o_fault_rate(o_fault_rate),
    .o_timer_preset(o_timer_preset), .o_mute_angle(o_mute_angle),
    .o_prog_busy(o_prog_busy), .o_prog_done(o_prog_done));
`default_nettype wire

/* File: tb/resolver_model.sv */
// partner: resolver shaft angle source
`timescale 1ns/1ps
`default_nettype none
module resolver_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // motion control
    input wire logic i_run,
    input wire logic [8:0] i_step,
    // resolver angle
    output logic [8:0] o_angle
);
    logic [9:0] sum;
    // shaft turns a step per cycle, wrapping at 360
    assign sum = {1'b0, o_angle} + {1'b0, i_step};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_angle <= 9'h014;
        end else if (i_run) begin
            o_angle <= (sum >= 10'h168) ? 9'(sum - 10'h168) : sum[8:0];
        end
    end
endmodule // resolver_model
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench: press motion supervisor scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst, run, brk, frst, sflt, tsel, pp_n, sp_n, step_e;
    logic preq, pconf, sel, mov, mot, tstop, flt, done;
    logic [5:0] set_s, sslot, slot, tgt;
    logic [9:0] val, rate, frate, tmr;
    logic [8:0] raw, step, pos, ofs, mute;
    logic [47:0] pname, sname;
    logic [31:0] pdata;
    press_motion_pkg::prog_op_e pop;
    int n_fail, checked, n;
    // ==================================================
    // clock, partner and design
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    resolver_model shaft (.i_clk(clk), .i_rst(rst), .i_run(run),
        .i_step(step), .o_angle(raw));
    press_motion_supervisor #(.TICK_CYCLES(4), .MIN_CYCLES(600)) uut (
        .i_clk(clk), .i_rst(rst), .i_raw_angle(raw), .i_brake(brk),
        .i_fault_reset(frst), .i_stop_fault(sflt), .i_top_stop_sel(tsel),
        .i_program_permit_n(pp_n), .i_supervisor_permit_n(sp_n),
        .i_set_offset(set_s[0]), .i_set_upper(set_s[1]),
        .i_set_lower(set_s[2]), .i_set_timer(set_s[3]),
        .i_set_top(set_s[4]), .i_set_mute(set_s[5]),
        .i_step_entry(step_e), .i_set_value(val), .i_prog_req(preq),
        .i_prog_op(pop), .i_prog_confirm(pconf), .i_prog_target(tgt),
        .i_prog_name(pname), .i_prog_data(pdata), .i_select(sel),
        .i_select_slot(sslot), .o_position(pos), .o_offset(ofs),
        .o_stroke_rate(rate), .o_moving(mov), .o_motion(mot),
        .o_top_stop(tstop), .o_immediate_stop(), .o_no_motion_fault(flt),
        .o_fault_rate(frate), .o_upper_rate_limit(), .o_lower_rate_limit(),
        .o_timer_preset(tmr), .o_top_angle(), .o_mute_angle(mute),
        .o_set_refused(), .o_tool_program_slot(slot), .o_slot_name(sname),
        .o_slot_data(), .o_prog_busy(), .o_prog_done(done),
        .o_prog_bad_name());
    // ==================================================
    // compare, report and access tasks
    task automatic chk(input logic [47:0] seen, exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tmo(input string what);
        n_fail++;
        $display("[FAIL] %s exp done seen timeout", what);
        wrap_up;
    endtask
    task automatic setv(input int k, input logic [9:0] v);
        @(negedge clk);
        val = v;
        set_s[k] = 1'b1;
        @(negedge clk);
        set_s = 6'h00;
        repeat (3) @(negedge clk);
    endtask
    task automatic pick(input logic [5:0] s);
        @(negedge clk);
        sslot = s;
        sel = 1'b1;
        @(negedge clk);
        sel = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic prog(input press_motion_pkg::prog_op_e op, input logic c);
        @(negedge clk);
        pop = op;
        pconf = c;
        preq = 1'b1;
        @(negedge clk);
        preq = 1'b0;
        for (n = 0; n < 300 && done !== 1'b1; n++) @(negedge clk);
        if (n == 300) tmo("prog");
        repeat (2) @(negedge clk);
    endtask
    // ==================================================
    // main sequence
    initial begin
        {rst, brk, pp_n, sp_n} = 4'hF;
        {run, frst, sflt, tsel, preq, pconf, sel, step_e} = 8'h00;
        {set_s, sslot} = 12'h000;
        {val, step, tgt} = {10'h000, 9'h024, 6'h02};
        pop = press_motion_pkg::OP_NONE;
        pname = 48'h000000000000;
        pdata = 32'h000000A5;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        setv(0, 10'h00A);
        chk(ofs, 9'h000, "offset no permit");
        pp_n = 1'b0;
        setv(0, 10'h00A);
        chk(ofs, 9'h000, "offset one permit");
        sp_n = 1'b0;
        setv(0, 10'h15E);
        chk(ofs, 9'h15E, "offset");
        chk(pos, 9'h00A, "position");
        setv(0, 10'h168);
        chk(ofs, 9'h15E, "offset 360");
        setv(3, 10'h3E8);
        chk(tmr, 10'h3E7, "preset over");
        setv(3, 10'h3E7);
        chk(tmr, 10'h3E7, "preset max");
        setv(3, 10'h002);
        setv(5, 10'h059);
        chk(mute, 9'h0BE, "mute 89");
        setv(5, 10'h0BE);
        chk(mute, 9'h0BE, "mute 190");
        setv(1, 10'h064);
        setv(2, 10'h014);
        setv(4, 10'h064);
        run = 1'b1;
        repeat (60) @(negedge clk);
        chk(rate, 10'h03C, "rate");
        setv(0, 10'h005);
        chk(ofs, 9'h15E, "offset moving");
        step_e = 1'b1;
        setv(0, 10'h005);
        chk(ofs, 9'h15E, "offset step moving");
        step_e = 1'b0;
        brk = 1'b0;
        repeat (20) @(negedge clk);
        chk({flt, mot}, 2'h1, "rate in band");
        step = 9'h05A;
        brk = 1'b1;
        repeat (20) @(negedge clk);
        brk = 1'b0;
        for (n = 0; n < 100 && flt !== 1'b1; n++) @(negedge clk);
        if (n == 100) tmo("fault");
        chk(mot, 1'b0, "motion on fault");
        chk(frate, 10'h096, "fault rate");
        repeat (20) @(negedge clk);
        chk(flt, 1'b1, "fault held");
        frst = 1'b1;
        @(negedge clk);
        frst = 1'b0;
        repeat (2) @(negedge clk);
        chk(flt, 1'b0, "fault cleared");
        step = 9'h024;
        {tsel, sflt} = 2'h3;
        for (n = 0; n < 100 && tstop !== 1'b0; n++) @(negedge clk);
        if (n == 100) tmo("top stop");
        chk(pos >= 9'h064 && pos < 9'h0AC, 1'b1, "top");
        {tsel, sflt, run} = 3'h0;
        repeat (30) @(negedge clk);
        for (int k = 0; k < 64; k++) begin
            pick(6'(k));
            prog(press_motion_pkg::OP_DELETE, 1'b1);
        end
        pick(6'h01);
        pname = 48'h00000098294B;
        prog(press_motion_pkg::OP_RENAME, 1'b1);
        chk(sname, pname, "renamed");
        prog(press_motion_pkg::OP_COPY, 1'b0);
        pick(6'h02);
        chk(sname, 48'h0, "copy no");
        pick(6'h01);
        prog(press_motion_pkg::OP_COPY, 1'b1);
        pick(6'h02);
        chk(sname, pname, "copy yes");
        prog(press_motion_pkg::OP_DELETE, 1'b0);
        chk(sname, pname, "delete no");
        prog(press_motion_pkg::OP_DELETE, 1'b1);
        chk(sname, 48'h0, "delete yes");
        pname = 48'h9A69A69A698B;
        prog(press_motion_pkg::OP_SEARCH, 1'b0);
        chk(slot, 6'h01, "search hit");
        prog(press_motion_pkg::OP_SEARCH, 1'b0);
        chk(slot, 6'h01, "search wrap");
        pname = 48'h9A69A69A698C;
        prog(press_motion_pkg::OP_SEARCH, 1'b0);
        chk(slot, 6'h01, "search miss");
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
